// ==== src/clock_ctrl_defs.vh ====
/*
  Constants of the clock controller: register offsets, field positions,
  reset values, divider ratios and tone periods.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef CLOCK_CTRL_DEFS_VH
`define CLOCK_CTRL_DEFS_VH

// register offsets (8-bit byte addresses)
`define ADDR_CLOCK_RTC_CONTROL_STATUS 8'h2C
`define ADDR_TONE_CONTROL_REGISTER 8'h2D
`define ADDR_EVENT_STATUS 8'h2E
`define ADDR_EVENT_MASK 8'h2F

// control/status register fields
`define CSR_CLOCK_OUT_SELECT 7
`define CSR_SLOW_DIV_HI 6
`define CSR_SLOW_DIV_LO 5
`define CSR_SLOW_MODE_SELECT 4
`define CSR_TIMEBASE_HI 3
`define CSR_TIMEBASE_LO 2
`define CSR_TIMEBASE_IRQ_ENABLE 1
`define CSR_TIMEBASE_IRQ_FLAG 0
`define CSR_RESET 8'h00
`define TONE_RESET 2'h0

// event status bits
`define EVT_TIMEBASE 0
`define EVT_HALT_WAKE 1
`define EVT_WIDTH 2

// timebase division of the oscillator clock
`define TB_DIV_00 16000
`define TB_DIV_01 32000
`define TB_DIV_10 80000
`define TB_DIV_11 200000

// tone generation from the oscillator clock
`define OSC_HZ 8000000
`define TONE_HZ_01 2000
`define TONE_HZ_10 1000
`define TONE_HZ_11 500
`define TONE_HALF_01 (`OSC_HZ / (2 * `TONE_HZ_01))
`define TONE_HALF_10 (`OSC_HZ / (2 * `TONE_HZ_10))
`define TONE_HALF_11 (`OSC_HZ / (2 * `TONE_HZ_11))

`endif

// ==== src/clock_ctrl.v ====
/*
  Main clock controller: CPU clock prescaler, clock-out, real-time timebase
  with interrupt flag, beeper, halt mode tracking and a small event block.
  Assumes a single oscillator clock, synchronous inputs, and a register
  master that pulses one strobe per access with read data taken next cycle.
*/
`timescale 1ns/1ps
`include "clock_ctrl_defs.vh"

module clock_ctrl #(
  parameter TB_DIV_00 = `TB_DIV_00,
  parameter TB_DIV_01 = `TB_DIV_01,
  parameter TB_DIV_10 = `TB_DIV_10,
  parameter TB_DIV_11 = `TB_DIV_11,
  parameter TONE_HALF_01 = `TONE_HALF_01,
  parameter TONE_HALF_10 = `TONE_HALF_10,
  parameter TONE_HALF_11 = `TONE_HALF_11
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  output reg [7:0] rd_data_o,
  input wire halt_req_i,
  input wire wait_i,
  input wire halt_wake_i,
  output reg active_halt_o,
  output reg halt_o,
  output reg cpu_clk_en_o,
  output reg clock_out_o,
  output reg clock_out_oe_n_o,
  output reg beep_o,
  output reg beep_oe_n_o,
  output reg timebase_irq_o,
  output reg irq_o
);

  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_ACTIVE_HALT = 2'h1;
  localparam [1:0] ST_HALT = 2'h2;

  function [17:0] tb_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: tb_limit = TB_DIV_00[17:0] - 18'h00001;
        2'h1: tb_limit = TB_DIV_01[17:0] - 18'h00001;
        2'h2: tb_limit = TB_DIV_10[17:0] - 18'h00001;
        default: tb_limit = TB_DIV_11[17:0] - 18'h00001;
      endcase
    end
  endfunction

  function [12:0] tone_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: tone_limit = TONE_HALF_01[12:0] - 13'h0001;
        2'h2: tone_limit = TONE_HALF_10[12:0] - 13'h0001;
        default: tone_limit = TONE_HALF_11[12:0] - 13'h0001;
      endcase
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:1] csr_q;
  reg flag_q;
  reg [1:0] tone_sel_q;
  reg [1:0] tb_act_q;
  reg [17:0] tb_cnt_q;
  reg [3:0] pre_q;
  reg [12:0] tone_cnt_q;
  reg [`EVT_WIDTH-1:0] evt_status_q;
  reg [`EVT_WIDTH-1:0] evt_mask_q;
  reg [`EVT_WIDTH-1:0] evt_set;
  reg [`EVT_WIDTH-1:0] evt_clr;
  reg [`EVT_WIDTH-1:0] evt_status_d;
  reg [7:1] csr_d;
  reg [1:0] tone_sel_d;
  reg flag_d;
  reg [17:0] tb_cnt_d;
  reg [1:0] tb_act_d;
  reg [12:0] tone_cnt_d;
  reg beep_d;
  reg [7:0] rd_mux;
  wire [7:0] csr_reset_value = `CSR_RESET;

  wire in_halt = (state_q == ST_HALT);
  wire in_active_halt = (state_q == ST_ACTIVE_HALT);
  wire running = (state_q == ST_RUN);
  wire sel_csr = (addr_i == `ADDR_CLOCK_RTC_CONTROL_STATUS);
  wire sel_tone = (addr_i == `ADDR_TONE_CONTROL_REGISTER);
  wire sel_stat = (addr_i == `ADDR_EVENT_STATUS);
  wire sel_mask = (addr_i == `ADDR_EVENT_MASK);
  // control and tone registers take writes only while the core runs; event status and mask take them in any state; wait mode changes nothing
  wire reg_wr = wr_stb_i && running;
  wire [1:0] slow_div = csr_q[`CSR_SLOW_DIV_HI:`CSR_SLOW_DIV_LO];
  wire slow_mode = csr_q[`CSR_SLOW_MODE_SELECT];
  wire [1:0] tb_sel = csr_q[`CSR_TIMEBASE_HI:`CSR_TIMEBASE_LO];
  wire tb_ie = csr_q[`CSR_TIMEBASE_IRQ_ENABLE];
  wire clk_out_sel = csr_q[`CSR_CLOCK_OUT_SELECT];
  wire tb_end = !in_halt && (tb_cnt_q == tb_limit(tb_act_q));
  wire csr_read = rd_stb_i && sel_csr;
  reg cpu_tick;

  // halt mode tracking
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if (halt_req_i)
          state_d = tb_ie ? ST_ACTIVE_HALT : ST_HALT;
      end
      ST_ACTIVE_HALT:
      begin
        if ((tb_end && tb_ie) || halt_wake_i)
          state_d = ST_RUN;
      end
      ST_HALT:
      begin
        if (halt_wake_i)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_RUN;
      active_halt_o <= 1'b0;
      halt_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      active_halt_o <= (state_d == ST_ACTIVE_HALT);
      halt_o <= (state_d == ST_HALT);
    end
  end

  // control registers and timebase flag
  always @*
  begin
    csr_d = csr_q;
    tone_sel_d = tone_sel_q;
    if (reg_wr && sel_csr)
      csr_d = wr_data_i[7:1];
    if (reg_wr && sel_tone)
      tone_sel_d = wr_data_i[1:0];
  end

  // a period end in the cycle of a clearing read keeps the flag
  always @*
  begin
    if (tb_end)
      flag_d = 1'b1;
    else if (csr_read)
      flag_d = 1'b0;
    else
      flag_d = flag_q;
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      csr_q <= csr_reset_value[7:1];
      flag_q <= 1'b0;
      tone_sel_q <= `TONE_RESET;
    end
    else
    begin
      csr_q <= csr_d;
      flag_q <= flag_d;
      tone_sel_q <= tone_sel_d;
    end
  end

  // timebase counter; selection latched at period end
  always @*
  begin
    tb_cnt_d = tb_cnt_q;
    tb_act_d = tb_act_q;
    if (tb_end)
    begin
      tb_cnt_d = 18'h00000;
      tb_act_d = tb_sel;
    end
    else if (!in_halt)
      tb_cnt_d = tb_cnt_q + 18'h00001;
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tb_cnt_q <= 18'h00000;
      tb_act_q <= 2'h0;
    end
    else
    begin
      tb_cnt_q <= tb_cnt_d;
      tb_act_q <= tb_act_d;
    end
  end

  // prescaler taps: tap g is high once every 2^(g+1) cycles
  wire [3:0] tap_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_tap
      assign tap_hit[g] = &pre_q[g:0];
    end
  endgenerate

  // cpu clock prescaler
  always @*
  begin
    if (!slow_mode)
      cpu_tick = 1'b1;
    else
      cpu_tick = tap_hit[slow_div];
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pre_q <= 4'h0;
      cpu_clk_en_o <= 1'b0;
      clock_out_o <= 1'b0;
      clock_out_oe_n_o <= 1'b1;
    end
    else
    begin
      if (!in_halt)
        pre_q <= pre_q + 4'h1;
      cpu_clk_en_o <= running && cpu_tick;
      clock_out_oe_n_o <= !clk_out_sel;
      if (!clk_out_sel || !running)
        clock_out_o <= 1'b0;
      else if (cpu_tick)
        clock_out_o <= !clock_out_o;
    end
  end

  // beeper; keeps running in active halt, oscillator stops in halt
  always @*
  begin
    tone_cnt_d = tone_cnt_q;
    beep_d = beep_o;
    if (tone_sel_q == 2'h0)
    begin
      tone_cnt_d = 13'h0000;
      beep_d = 1'b0;
    end
    else if (!in_halt)
    begin
      if (tone_cnt_q >= tone_limit(tone_sel_q))
      begin
        tone_cnt_d = 13'h0000;
        beep_d = !beep_o;
      end
      else
        tone_cnt_d = tone_cnt_q + 13'h0001;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tone_cnt_q <= 13'h0000;
      beep_o <= 1'b0;
      beep_oe_n_o <= 1'b1;
    end
    else
    begin
      beep_oe_n_o <= (tone_sel_q == 2'h0);
      tone_cnt_q <= tone_cnt_d;
      beep_o <= beep_d;
    end
  end

  // event status, mask and interrupt outputs
  always @*
  begin
    evt_set = {`EVT_WIDTH{1'b0}};
    evt_set[`EVT_TIMEBASE] = tb_end;
    evt_set[`EVT_HALT_WAKE] = !running && (state_d == ST_RUN);
  end

  // write one to clear; a new event in the same cycle keeps its bit
  always @*
  begin
    if (wr_stb_i && sel_stat)
      evt_clr = wr_data_i[`EVT_WIDTH-1:0];
    else
      evt_clr = {`EVT_WIDTH{1'b0}};
    evt_status_d = (evt_status_q & ~evt_clr) | evt_set;
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      evt_status_q <= {`EVT_WIDTH{1'b0}};
      evt_mask_q <= {`EVT_WIDTH{1'b0}};
      timebase_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      evt_status_q <= evt_status_d;
      if (wr_stb_i && sel_mask)
        evt_mask_q <= wr_data_i[`EVT_WIDTH-1:0];
      // requests follow flag and status as they stand after this edge
      timebase_irq_o <= tb_ie && flag_d;
      irq_o <= |(evt_status_d & evt_mask_q);
    end
  end

  // read data, one cycle after the strobe
  always @*
  begin
    if (sel_csr)
      rd_mux = {csr_q, flag_q};
    else if (sel_tone)
      rd_mux = {6'h00, tone_sel_q};
    else if (sel_stat)
      rd_mux = {{(8 - `EVT_WIDTH){1'b0}}, evt_status_q};
    else if (sel_mask)
      rd_mux = {{(8 - `EVT_WIDTH){1'b0}}, evt_mask_q};
    else
      rd_mux = 8'h00;
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      rd_data_o <= 8'h00;
    else if (rd_stb_i)
      rd_data_o <= rd_mux;
    else
      rd_data_o <= 8'h00;
  end

endmodule // clock_ctrl

// ==== verification/clock_ctrl_checker.sv ====
/* port assertions of the clock controller
   assumes one clock and a sync reset */
`timescale 1ns/1ps
module clock_ctrl_checker (
  input logic sys_clk_i, reset_i, wr_stb_i, rd_stb_i, halt_req_i, wait_i, halt_wake_i,
  input logic [7:0] addr_i, wr_data_i, rd_data_o,
  input logic active_halt_o, halt_o, cpu_clk_en_o, clock_out_o, clock_out_oe_n_o,
  input logic beep_o, beep_oe_n_o, timebase_irq_o, irq_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_csr_rd;
    rd_stb_i && addr_i == 8'h2C && !$past(wr_stb_i);
  endsequence
  sequence s_ah;
    active_halt_o ##1 active_halt_o;
  endsequence
  sequence s_halt;
    halt_o ##1 halt_o;
  endsequence
  property p_flag_rd;
    s_csr_rd ##0 timebase_irq_o |=> rd_data_o[1:0] == 2'h3;
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag read");
  property p_ah_out;
    s_ah |-> !cpu_clk_en_o && !clock_out_o;
  endproperty
  a_ah_out: assert property (p_ah_out) else $error("clock in halt");
  property p_frozen;
    s_halt |-> $stable(beep_o) && !clock_out_o;
  endproperty
  a_frozen: assert property (p_frozen) else $error("not frozen");
  property p_halt_hold;
    halt_o && !halt_wake_i && !$past(halt_wake_i) |=> halt_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left");
  property p_ah_wake;
    active_halt_o && halt_wake_i |-> ##[1:2] !active_halt_o;
  endproperty
  a_ah_wake: assert property (p_ah_wake) else $error("no wake");
  property p_tb_wake;
    $rose(timebase_irq_o) && $past(active_halt_o) |-> ##[0:2] !active_halt_o;
  endproperty
  a_tb_wake: assert property (p_tb_wake) else $error("no timebase wake");
  property p_enter;
    halt_req_i && !halt_o && !active_halt_o |=> halt_o != active_halt_o;
  endproperty
  a_enter: assert property (p_enter) else $error("no halt");
  property p_cause;
    $rose(halt_o) || $rose(active_halt_o) |-> $past(halt_req_i);
  endproperty
  a_cause: assert property (p_cause) else $error("halt uncaused");
endmodule // clock_ctrl_checker

bind clock_ctrl clock_ctrl_checker checker_i (.sys_clk_i, .reset_i, .wr_stb_i, .rd_stb_i,
  .halt_req_i, .wait_i, .halt_wake_i, .addr_i, .wr_data_i, .rd_data_o, .active_halt_o,
  .halt_o, .cpu_clk_en_o, .clock_out_o, .clock_out_oe_n_o, .beep_o, .beep_oe_n_o,
  .timebase_irq_o, .irq_o);

// ==== verification/wake_source.sv ====
/* interrupt source able to exit halt
   assumes start pulse; zero delay means never */
`timescale 1ns/1ps
module wake_source (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [9:0] dly_i,
  output logic wake_o
);
  logic [9:0] cnt_q;
  always @(posedge sys_clk_i)
  begin
    wake_o <= 1'b0;
    if (reset_i || start_i)
      cnt_q <= reset_i ? 10'h000 : dly_i;
    else if (cnt_q != 10'h000)
    begin
      cnt_q <= cnt_q - 10'h001;
      wake_o <= cnt_q == 10'h001;
    end
  end
endmodule // wake_source

// ==== verification/clock_ctrl_bench.sv ====
/* bench of the clock controller
   assumes short divider parameters */
`timescale 1ns/1ps
module clock_ctrl_bench;
  logic sys_clk_i = 0, reset_i = 1, wr_stb_i = 0, rd_stb_i = 0, halt_req_i = 0, wait_i = 0;
  logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o, d, q;
  logic halt_wake_i, active_halt_o, halt_o, cpu_clk_en_o, clock_out_o, clock_out_oe_n_o;
  logic beep_o, beep_oe_n_o, timebase_irq_o, irq_o, go = 0;
  logic [9:0] dly = 0;
  logic [1:0] c, p;
  logic [31:0] r = 32'h16117AD1, nb, nc, no, t0, t1, t2, k, e;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  clock_ctrl #(.TB_DIV_00(16), .TB_DIV_01(32), .TB_DIV_10(80), .TB_DIV_11(200),
    .TONE_HALF_01(4)) uut (.sys_clk_i, .reset_i,
    .addr_i, .wr_data_i, .wr_stb_i, .rd_stb_i, .rd_data_o, .halt_req_i, .wait_i,
    .halt_wake_i, .active_halt_o, .halt_o, .cpu_clk_en_o, .clock_out_o, .clock_out_oe_n_o,
    .beep_o, .beep_oe_n_o, .timebase_irq_o, .irq_o);
  wake_source partner (.sys_clk_i, .reset_i, .start_i(go), .dly_i(dly), .wake_o(halt_wake_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  function automatic logic [31:0] tb_len(input logic [1:0] s);
    return s == 2'h0 ? 16 : s == 2'h1 ? 32 : s == 2'h2 ? 80 : 200;
  endfunction
  // half tone period: code 01 shortened, others 8 MHz over twice the tone
  function automatic logic [31:0] tone_half(input logic [1:0] s);
    return s == 2'h1 ? 4 : s == 2'h2 ? 8000000 / 2000 : 8000000 / 1000;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_stb_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_stb_i <= 1'b0;
    #1 v = rd_data_o;
  endtask
  // wait for a timebase request, bounded
  task hi(output logic [31:0] t);
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1 k++;
    end while (timebase_irq_o !== 1'b1 && k < 1000);
    if (k == 1000) n_errors++;
    t = cyc;
  endtask
  // count cpu ticks and pin toggles
  task watch(input int n);
    logic b, o;
    nb = 0;
    nc = 0;
    no = 0;
    @(posedge sys_clk_i);
    #1 b = beep_o;
    o = clock_out_o;
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1 nc += cpu_clk_en_o;
      nb += beep_o ^ b;
      no += clock_out_o ^ o;
      b = beep_o;
      o = clock_out_o;
    end
  endtask
  task halt(input logic en, input logic [9:0] w, input logic [31:0] x);
    hi(t0);
    rd(8'h2C, q);
    wr(8'h2C, {6'h03, en, 1'h0});
    @(posedge sys_clk_i);
    halt_req_i <= 1'b1;
    go <= 1'b1;
    dly <= w;
    @(posedge sys_clk_i);
    halt_req_i <= 1'b0;
    go <= 1'b0;
    #1 chk("mode", {active_halt_o, halt_o}, {en, !en});
    watch(16);
    chk("hbeep", nb, en ? 4 : 0);
    k = 17;
    while ((active_halt_o | halt_o) === 1'b1 && k < 400)
    begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    chk("exit", k + 8 - x < 16, 1'b1);
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(8'h2C, q);
    chk("csr", q, 8'h00);
    rd(8'h30, q);
    chk("unmapped", q, 8'h00);
    chk("oe", {clock_out_oe_n_o, beep_oe_n_o}, 2'h3);
    for (int i = 0; i < 5; i++)
    begin
      r = lfsr(r);
      d = {r[7] | (i == 0), i[1:0], i != 4, 3'h0, r[0]};
      wait_i <= r[3];
      wr(8'h2C, d);
      repeat (16) @(posedge sys_clk_i);
      watch(64);
      e = d[4] ? 64 >> d[6:5] >> 1 : 64;
      chk("cpu", nc, e);
      if (d[7]) chk("clkout", no, e);
      chk("cko_oe", clock_out_oe_n_o, !d[7]);
      rd(8'h2C, q);
      chk("csr", q[7:1], d[7:1]);
    end
    wait_i <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h2D, 8'h00);
      wr(8'h2D, c[7:0]);
      repeat (40) @(posedge sys_clk_i);
      watch(8000);
      chk("tone", nb, c ? 8000 / tone_half(c[1:0]) : 0);
      chk("tone_oe", beep_oe_n_o, c == 0);
      rd(8'h2D, q);
      chk("tone_reg", q, c);
    end
    wr(8'h2C, 8'h02);
    rd(8'h2C, q);
    p = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(3 - i);
      hi(t0);
      rd(8'h2C, q);
      chk("flag", q[0], 1'b1);
      wr(8'h2C, {4'h0, c, 2'h3});
      rd(8'h2C, q);
      chk("clear", q[1:0], 2'h2);
      hi(t1);
      chk("old", t1 - t0, tb_len(p));
      rd(8'h2C, q);
      hi(t2);
      chk("new", t2 - t1, tb_len(c));
      rd(8'h2C, q);
      p = c;
    end
    wr(8'h2C, 8'h0E);
    hi(t0);
    rd(8'h2C, q);
    wr(8'h2F, 8'h00);
    rd(8'h2E, q);
    chk("event", q[0], 1'b1);
    chk("masked", irq_o, 1'b0);
    wr(8'h2F, 8'h01);
    @(posedge sys_clk_i);
    #1 chk("irq", irq_o, 1'b1);
    wr(8'h2E, 8'h01);
    @(posedge sys_clk_i);
    #1 chk("irq_clr", irq_o, 1'b0);
    wr(8'h2D, 8'h01);
    halt(1'b1, 10'h000, 194);
    halt(1'b1, 10'h01E, 31);
    halt(1'b0, 10'h0FA, 251);
    conclude();
  end
endmodule // clock_ctrl_bench
